// *** hdl/region_select.sv ***
// Region choice, address forming and bound checks for one window access
`include "window_limits_defs.svh"

module region_select (
    // Window offset
    input wire logic [15:0] window_offset,
    // Region settings
    input wire logic [29:0] region0_base,
    input wire logic [29:0] region1_base,
    input wire logic [12:0] region0_read_bound,
    input wire logic [12:0] region0_write_bound,
    input wire logic [12:0] region1_read_bound,
    input wire logic [12:0] region1_write_bound,
    // Results
    output logic [31:0] mem_address,
    output logic read_ok,
    output logic write_ok
);

    // ------------------------------------------------------------------------
    // Word offset strictly below a bound
    // ------------------------------------------------------------------------
    function automatic logic below_bound(input logic [12:0] word, input logic [12:0] bound);
        below_bound = word < bound;
    endfunction

    wire region_one = window_offset[`WL_REGION_BIT];
    wire [12:0] offset_upper_word_bits = window_offset[`WL_OFFSET_MSB:`WL_WORD_LSB];
    wire [29:0] base = region_one ? region1_base : region0_base;
    wire [12:0] read_bound = region_one ? region1_read_bound : region0_read_bound;
    wire [12:0] write_bound = region_one ? region1_write_bound : region0_write_bound;

    // Base plus 15-bit offset
    assign mem_address = {base, 2'b00} + {17'h00000, window_offset[`WL_OFFSET_MSB:0]};
    assign read_ok = below_bound(offset_upper_word_bits, read_bound);
    assign write_ok = below_bound(offset_upper_word_bits, write_bound);

endmodule

// *** hdl/shared_memory_window_limits.sv ***
// Shared memory window: region choice, read and write bounds, data window
//
// How it works
// - A data window read with region bit 0 checks bits 14:2 against the region 0 read bound.
// - That read fills the data window from memory only when the word offset is below the bound.
// - A data window byte write with region bit 0 checks the word offset against the write bound.
// - Below the write bound, only the byte lanes the host wrote go to memory.
// - At or above the write bound, the memory write is suppressed entirely.
// - With region bit 1 the region 1 base register is used.
// - A region 1 access addresses memory at region 1 base plus the window offset.
// - Region 1 base is writable in bits 31:2, bits 1:0 read zero, and it resets to zero.
// - Region 0 read and write bounds are writable in bits 14:2, other bits zero, reset zero.
// - With region bit 0 memory is addressed at region 0 base plus the window offset.
// - With region bit 1 reads check the region 1 read bound before filling the window.
`include "window_limits_defs.svh"

module shared_memory_window_limits (
    // Clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // Register port
    input wire logic [11:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // Internal memory
    output logic [31:0] MEM_ADDR,
    output logic MEM_RD,
    output logic MEM_WR,
    output logic [3:0] MEM_BE,
    output logic [31:0] MEM_WDATA,
    input wire logic [31:0] MEM_RDATA
);

    // ------------------------------------------------------------------------
    // Lane decoding
    // ------------------------------------------------------------------------
    function automatic logic [3:0] lane_mask(input logic [1:0] lane);
        lane_mask = 4'h1 << lane;
    endfunction

    function automatic logic [31:0] bound_word(input logic [12:0] bound);
        bound_word = {17'h00000, bound, 2'b00};
    endfunction

    function automatic logic [31:0] base_word(input logic [29:0] base);
        base_word = {base, 2'b00};
    endfunction

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic [15:0] window_offset;
    logic [29:0] region0_base;
    logic [29:0] region1_base;
    logic [12:0] region0_read_bound;
    logic [12:0] region0_write_bound;
    logic [12:0] region1_read_bound;
    logic [12:0] region1_write_bound;
    logic read_refused;
    logic write_refused;
    window_limits_pkg::fill_state_type fill_state;
    window_limits_pkg::fill_state_type next_fill_state;

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    wire hit_offset = ADDR == `WL_OFFSET_ADDR;
    wire hit_data = ADDR[11:2] == 10'(`WL_DATA_ADDR >> 2);
    wire hit_status = ADDR == `WL_STATUS_ADDR;
    wire hit_base0 = ADDR == `WL_REGION0_BASE_ADDR;
    wire hit_r0_read = ADDR == `WL_R0_READ_ADDR;
    wire hit_r0_write = ADDR == `WL_R0_WRITE_ADDR;
    wire hit_base1 = ADDR == `WL_REGION1_BASE_ADDR;
    wire hit_r1_read = ADDR == `WL_R1_READ_ADDR;
    wire hit_r1_write = ADDR == `WL_R1_WRITE_ADDR;
    wire [1:0] lane = ADDR[1:0];

    wire data_read = RD && hit_data;
    wire data_write = WR && hit_data;

    // ------------------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------------------
    wire write_offset = WR && hit_offset;
    wire write_base0 = WR && hit_base0;
    wire write_base1 = WR && hit_base1;
    wire write_r0_read = WR && hit_r0_read;
    wire write_r0_write = WR && hit_r0_write;
    wire write_r1_read = WR && hit_r1_read;
    wire write_r1_write = WR && hit_r1_write;

    // Reserved bits are cut off here and read back as zero
    wire [15:0] offset_field = WDATA[15:0];
    wire [29:0] base_field = WDATA[`WL_BASE_MSB:`WL_BASE_LSB];
    wire [12:0] bound_field = WDATA[`WL_BOUND_MSB:`WL_BOUND_LSB];

    // ------------------------------------------------------------------------
    // Region choice and bound checks
    // ------------------------------------------------------------------------
    logic [31:0] access_address;
    logic read_ok;
    logic write_ok;

    // A new offset applies from the next window access on
    region_select u_region_select (
        .window_offset(window_offset),
        .region0_base(region0_base),
        .region1_base(region1_base),
        .region0_read_bound(region0_read_bound),
        .region0_write_bound(region0_write_bound),
        .region1_read_bound(region1_read_bound),
        .region1_write_bound(region1_write_bound),
        .mem_address(access_address),
        .read_ok(read_ok),
        .write_ok(write_ok)
    );

    // Read attempts start a fill only inside the bound
    wire fill_start = data_read && read_ok;
    wire write_go = data_write && write_ok;

    // ------------------------------------------------------------------------
    // Data window
    // ------------------------------------------------------------------------
    logic [31:0] window;
    wire [3:0] byte_we = data_write ? lane_mask(lane) : 4'h0;
    wire fill_load = fill_state == window_limits_pkg::FILL_CAPTURE;

    // Host byte writes win over a fill landing in the same cycle
    // Refused reads never raise the load, so the window holds
    window_data u_window_data (
        .clk(CLK),
        .srst(SRST),
        .load(fill_load),
        .load_data(MEM_RDATA),
        .byte_we(byte_we),
        .byte_data(WDATA[7:0]),
        .window(window)
    );

    // ------------------------------------------------------------------------
    // Fill sequence
    // ------------------------------------------------------------------------
    // Capture runs in the cycle after the memory read, when its data stand
    always_comb begin
        case (fill_state)
            window_limits_pkg::FILL_IDLE: begin
                next_fill_state = MEM_RD ? window_limits_pkg::FILL_CAPTURE
                                         : window_limits_pkg::FILL_IDLE;
            end
            window_limits_pkg::FILL_CAPTURE: begin
                next_fill_state = MEM_RD ? window_limits_pkg::FILL_CAPTURE
                                         : window_limits_pkg::FILL_IDLE;
            end
            default: begin
                next_fill_state = window_limits_pkg::FILL_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            fill_state <= window_limits_pkg::FILL_IDLE;
        end else begin
            fill_state <= next_fill_state;
        end
    end

    // ------------------------------------------------------------------------
    // Memory request outputs
    // ------------------------------------------------------------------------
    wire [31:0] lane_data = {4{WDATA[7:0]}};
    wire mem_request = fill_start || write_go;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            MEM_RD <= 1'b0;
        end else begin
            MEM_RD <= fill_start;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            MEM_WR <= 1'b0;
        end else begin
            MEM_WR <= write_go;
        end
    end

    // Address, lanes and data hold until the next accepted request
    always_ff @(posedge CLK) begin
        if (SRST) begin
            MEM_ADDR <= 32'h00000000;
        end else if (mem_request) begin
            MEM_ADDR <= access_address;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            MEM_BE <= 4'h0;
        end else if (mem_request) begin
            MEM_BE <= write_go ? lane_mask(lane) : 4'hF;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            MEM_WDATA <= 32'h00000000;
        end else if (mem_request) begin
            MEM_WDATA <= lane_data;
        end
    end

    // ------------------------------------------------------------------------
    // Outcome of the last window access
    // ------------------------------------------------------------------------
    // Each flag follows the last window access of its kind
    always_ff @(posedge CLK) begin
        if (SRST) begin
            read_refused <= 1'b0;
        end else if (data_read) begin
            read_refused <= !read_ok;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            write_refused <= 1'b0;
        end else if (data_write) begin
            write_refused <= !write_ok;
        end
    end

    // ------------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------------
    // Offset bit 15 picks the region for every later window access
    always_ff @(posedge CLK) begin
        if (SRST) begin
            window_offset <= `WL_OFFSET_RESET;
        end else if (write_offset) begin
            window_offset <= offset_field;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            region0_base <= `WL_BASE_RESET;
        end else if (write_base0) begin
            region0_base <= base_field;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            region1_base <= `WL_BASE_RESET;
        end else if (write_base1) begin
            region1_base <= base_field;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            region0_read_bound <= `WL_BOUND_RESET;
        end else if (write_r0_read) begin
            region0_read_bound <= bound_field;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            region0_write_bound <= `WL_BOUND_RESET;
        end else if (write_r0_write) begin
            region0_write_bound <= bound_field;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            region1_read_bound <= `WL_BOUND_RESET;
        end else if (write_r1_read) begin
            region1_read_bound <= bound_field;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            region1_write_bound <= `WL_BOUND_RESET;
        end else if (write_r1_write) begin
            region1_write_bound <= bound_field;
        end
    end

    // ------------------------------------------------------------------------
    // Read-back
    // ------------------------------------------------------------------------
    // Status bit 0 is high while a fill is in flight
    wire fill_busy = fill_load || MEM_RD;
    wire region_now = window_offset[`WL_REGION_BIT];
    wire [31:0] status_word = {28'h0000000,
                               region_now,
                               write_refused,
                               read_refused,
                               fill_busy};
    wire [31:0] offset_word = {16'h0000, window_offset};
    wire [31:0] base0_word = base_word(region0_base);
    wire [31:0] base1_word = base_word(region1_base);
    wire [31:0] r0_read_word = bound_word(region0_read_bound);
    wire [31:0] r0_write_word = bound_word(region0_write_bound);
    wire [31:0] r1_read_word = bound_word(region1_read_bound);
    wire [31:0] r1_write_word = bound_word(region1_write_bound);
    wire [31:0] data_word = window >> {lane, 3'b000};

    wire [31:0] read_value =
        hit_offset   ? offset_word :
        hit_data     ? data_word :
        hit_status   ? status_word :
        hit_base0    ? base0_word :
        hit_r0_read  ? r0_read_word :
        hit_r0_write ? r0_write_word :
        hit_base1    ? base1_word :
        hit_r1_read  ? r1_read_word :
        hit_r1_write ? r1_write_word :
        32'h00000000;

    // Read data stand one cycle, zero otherwise
    always_ff @(posedge CLK) begin
        if (SRST) begin
            RDATA <= 32'h00000000;
        end else if (RD) begin
            RDATA <= read_value;
        end else begin
            RDATA <= 32'h00000000;
        end
    end

endmodule

// *** hdl/window_data.sv ***
// 32-bit data window register, filled whole from memory or per byte by the host
module window_data (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Whole-word fill
    input wire logic load,
    input wire logic [31:0] load_data,
    // Host byte writes
    input wire logic [3:0] byte_we,
    input wire logic [7:0] byte_data,
    // Contents
    output logic [31:0] window
);

    genvar lane;
    generate
        for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
            always_ff @(posedge clk) begin
                if (srst) begin
                    window[lane*8 +: 8] <= 8'h00;
                end else if (byte_we[lane]) begin
                    window[lane*8 +: 8] <= byte_data;
                end else if (load) begin
                    window[lane*8 +: 8] <= load_data[lane*8 +: 8];
                end
            end
        end
    endgenerate

endmodule

// *** hdl/window_limits_defs.svh ***
// Register offsets, field positions and reset values of the shared memory window
`ifndef WINDOW_LIMITS_DEFS_SVH
`define WINDOW_LIMITS_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses on the register port)
// ----------------------------------------------------------------------------
`define WL_OFFSET_ADDR        12'h000
`define WL_DATA_ADDR          12'h004
`define WL_STATUS_ADDR        12'h008
`define WL_REGION0_BASE_ADDR  12'h104
`define WL_R0_READ_ADDR       12'h108
`define WL_R0_WRITE_ADDR      12'h10A
`define WL_REGION1_BASE_ADDR  12'h10C
`define WL_R1_READ_ADDR       12'h110
`define WL_R1_WRITE_ADDR      12'h112

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define WL_REGION_BIT         15
`define WL_OFFSET_MSB         14
`define WL_WORD_LSB           2
`define WL_BOUND_MSB          14
`define WL_BOUND_LSB          2
`define WL_BASE_MSB           31
`define WL_BASE_LSB           2
`define WL_STAT_BUSY          0
`define WL_STAT_READ_REFUSED  1
`define WL_STAT_WRITE_REFUSED 2
`define WL_STAT_REGION        3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define WL_OFFSET_RESET       16'h0000
`define WL_BOUND_RESET        13'h0000
`define WL_BASE_RESET         30'h00000000
`define WL_WINDOW_RESET       32'h00000000

`endif

// *** hdl/window_limits_pkg.sv ***
// Types shared by the shared memory window logic
package window_limits_pkg;

    // ------------------------------------------------------------------------
    // Window fill sequence
    // ------------------------------------------------------------------------
    typedef enum logic [0:0] {
        FILL_IDLE    = 1'b0,
        FILL_CAPTURE = 1'b1
    } fill_state_type;

endpackage

// *** tb/shared_memory_window_limits_tb.sv ***
// Self-checking bench of the shared memory window limits
module shared_memory_window_limits_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_prev = 1'b0;
    logic rref = 1'b0;
    logic wref = 1'b0;
    logic [31:0] rdata, mem_addr, mem_wdata, mem_rdata, win;
    logic mem_rd, mem_wr;
    logic [3:0] mem_be;
    int bad_count = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [31:0] rq [$];
    logic [68:0] mq [$];
    logic [31:0] mdl [0:1023];
    logic [12:0] rbound [2];
    logic [12:0] wbound [2];
    logic [31:0] rbase [2];

    always #50 clk = ~clk;

    shared_memory_window_limits u_dut (.CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .MEM_ADDR(mem_addr), .MEM_RD(mem_rd), .MEM_WR(mem_wr),
        .MEM_BE(mem_be), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata));
    window_memory u_mem (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    task automatic check(input logic [68:0] seen, input logic [68:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic bus(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
    endtask

    task automatic reg_read(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, 1'b1, a, 32'h0);
        rq.push_back(exp);
    endtask

    task automatic window_op(input logic rg, input logic [12:0] word, input logic write,
                             input logic [1:0] lane, input logic [7:0] b);
        logic [31:0] a;
        logic ok;
        a = rbase[rg] + {17'h0, word, 2'b00};
        ok = write ? (word < wbound[rg]) : (word < rbound[rg]);
        bus(1'b1, 1'b0, 12'h000, {16'h0, rg, word, 2'b00});
        if (write) begin
            bus(1'b1, 1'b0, 12'h004 | 12'(lane), {24'h0, b});
            win[8*lane +: 8] = b;
            wref = !ok;
            if (ok) mq.push_back({1'b1, 4'h1 << lane, a, {4{b}}});
            if (ok) mdl[a[11:2]][8*lane +: 8] = b;
        end else begin
            reg_read(12'h004 | 12'(lane), win >> {lane, 3'b000});
            rref = !ok;
            if (ok) mq.push_back({1'b0, 4'hF, a, 32'h0});
        end
        repeat (3) bus(1'b0, 1'b0, 12'h000, 32'h0);
        reg_read(12'h008, {28'h0, rg, wref, rref, 1'b0});
        if (ok && !write) win = mdl[a[11:2]];
    endtask

    // ----
    // Result watcher
    // ----
    always @(negedge clk) begin : watch
        logic [68:0] seen;
        if (rd_prev) begin
            seen = {37'h0, rdata};
            check(seen, rq.size() > 0 ? {37'h0, rq.pop_front()} : ~seen);
        end
        rd_prev = rd;
        if (mem_rd || mem_wr) begin
            seen = {mem_wr, mem_be, mem_addr, mem_wr ? mem_wdata : 32'h0};
            check(seen, mq.size() > 0 ? mq.pop_front() : ~seen);
        end
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    initial begin : main
        static logic [11:0] regs [7] = '{12'h104, 12'h108, 12'h10A, 12'h10C, 12'h110, 12'h112,
                                         12'h200};
        for (int i = 0; i < 1024; i++) mdl[i] = 32'hA5000000 | 32'(i);
        win = 32'h0;
        void'($urandom(32'h3e9a3712));
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        foreach (regs[i]) reg_read(regs[i], 32'h0);
        bus(1'b1, 1'b0, 12'h108, 32'hFFFFFFFF);
        reg_read(12'h108, 32'h00007FFC);
        bus(1'b1, 1'b0, 12'h10C, 32'hFFFFFFFF);
        reg_read(12'h10C, 32'hFFFFFFFC);
        $display("test registers done");
        bus(1'b1, 1'b0, 12'h108, 32'h10);
        bus(1'b1, 1'b0, 12'h10A, 32'h10);
        bus(1'b1, 1'b0, 12'h104, 32'h40);
        bus(1'b1, 1'b0, 12'h10C, 32'h100);
        bus(1'b1, 1'b0, 12'h110, 32'h8);
        bus(1'b1, 1'b0, 12'h112, 32'h8);
        rbound = '{13'd4, 13'd2};
        wbound = '{13'd4, 13'd2};
        rbase = '{32'h40, 32'h100};
        for (int i = 0; i < 60; i++) begin
            window_op(1'($urandom), 13'($urandom % 6), 1'($urandom), 2'($urandom), 8'($urandom));
        end
        $display("test window done");
        repeat (4) bus(1'b0, 1'b0, 12'h000, 32'h0);
        check(69'(rq.size() + mq.size()), 69'h0);
        tally_and_finish();
    end
endmodule

// *** tb/window_limits_properties.sv ***
// Checker of the window bound, address and readback relations
module window_limits_checker (
    // Clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // Register port
    input wire logic [11:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    // Internal memory
    input wire logic [31:0] MEM_ADDR,
    input wire logic MEM_RD,
    input wire logic MEM_WR,
    input wire logic [3:0] MEM_BE,
    input wire logic [31:0] MEM_WDATA,
    input wire logic [31:0] MEM_RDATA
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----
    // Shadow of the settings
    // ----
    logic [15:0] offs;
    logic [12:0] rb0, wb0, rb1, wb1;
    logic [29:0] base0, base1;
    logic [31:0] req_addr;
    logic [1:0] lane_q;
    logic [7:0] byte_q;
    wire logic data_sel = (ADDR[11:2] == 10'h001);
    wire logic [12:0] rd_bound = offs[15] ? rb1 : rb0;
    wire logic [12:0] wr_bound = offs[15] ? wb1 : wb0;
    wire logic rd_ok = offs[14:2] < rd_bound;
    wire logic wr_ok = offs[14:2] < wr_bound;
    wire logic [29:0] base = offs[15] ? base1 : base0;
    wire logic [31:0] next_req_addr = {base, 2'b00} + {17'h0, offs[14:0]};

    always_ff @(posedge CLK) begin
        lane_q <= ADDR[1:0];
        byte_q <= WDATA[7:0];
        if (SRST) begin
            {offs, rb0, wb0, rb1, wb1} <= 68'h0;
            {base0, base1, req_addr} <= 92'h0;
        end else begin
            if (WR && ADDR == 12'h000) offs <= WDATA[15:0];
            if (WR && ADDR == 12'h104) base0 <= WDATA[31:2];
            if (WR && ADDR == 12'h108) rb0 <= WDATA[14:2];
            if (WR && ADDR == 12'h10A) wb0 <= WDATA[14:2];
            if (WR && ADDR == 12'h10C) base1 <= WDATA[31:2];
            if (WR && ADDR == 12'h110) rb1 <= WDATA[14:2];
            if (WR && ADDR == 12'h112) wb1 <= WDATA[14:2];
            if ((WR || RD) && data_sel) req_addr <= next_req_addr;
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);

    AST_READ_FILL: assert property (
        RD && data_sel && rd_ok |=> MEM_RD && MEM_BE == 4'hF)
        else $error("window read below bound gave no fill");
    AST_READ_REFUSE: assert property (RD && data_sel && !rd_ok |=> !MEM_RD)
        else $error("window read at bound reached memory");
    AST_WRITE_LANE: assert property (
        WR && data_sel && wr_ok |=> MEM_WR && MEM_BE == (4'h1 << lane_q)
        && MEM_WDATA == {4{byte_q}})
        else $error("window write below bound gave wrong lanes");
    AST_WRITE_BLOCK: assert property (WR && data_sel && !wr_ok |=> !MEM_WR)
        else $error("window write at bound reached memory");
    AST_MEM_ADDR: assert property (MEM_RD || MEM_WR |-> MEM_ADDR == req_addr)
        else $error("memory address is not base plus offset");
    AST_BOUND_READ: assert property (
        RD && ADDR == 12'h108 |=> RDATA == {17'h0, rb0, 2'b00})
        else $error("read bound readback wrong");
    AST_BASE1_READ: assert property (RD && ADDR == 12'h10C |=> RDATA == {base1, 2'b00})
        else $error("region 1 base readback wrong");
    AST_RDATA_IDLE: assert property (!RD |=> RDATA == 32'h00000000)
        else $error("read data outside the read answer");
endmodule

bind shared_memory_window_limits window_limits_checker u_chk (.CLK(CLK), .SRST(SRST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD),
    .MEM_WR(MEM_WR), .MEM_BE(MEM_BE), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA));

// *** tb/window_memory.sv ***
// Behavioural internal memory answering the window's requests
module window_memory (
    // Clock
    input wire logic clk,
    // Requests
    input wire logic [31:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [3:0] mem_be,
    input wire logic [31:0] mem_wdata,
    // Read data
    output logic [31:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [0:1023];

    initial begin
        for (int i = 0; i < 1024; i++) mem[i] = 32'hA5000000 | 32'(i);
        mem_rdata = 32'h00000000;
    end

    // Answer right after a read, noise otherwise
    always @(posedge clk) begin
        mem_rdata <= mem_rd ? mem[mem_addr[11:2]] : ~mem_rdata;
        for (int l = 0; l < 4; l++) begin
            if (mem_wr && mem_be[l]) mem[mem_addr[11:2]][8*l +: 8] <= mem_wdata[8*l +: 8];
        end
    end
endmodule
